// [shared/iasg_pkg.sv]
// Package for the I2C address select and global address block
package iasg_pkg;

  localparam logic [6:0] IASG_GLOBAL_ADDR     = 7'h48;
  localparam logic [4:0] IASG_LOCAL_PREFIX    = 5'h13;
  localparam logic       IASG_GBL_EN_RESET    = 1'b1;
  localparam logic       IASG_REDETECT_RESET  = 1'b0;
  localparam logic [7:0] IASG_CKSUM_RESET     = 8'h00;
  localparam logic [1:0] IASG_STRAP_RESET     = 2'h0;
  localparam int         IASG_SETTLE_NS       = 40;
  localparam int         IASG_CLK_NS          = 10;
  localparam int         IASG_SETTLE_CYC      = (IASG_SETTLE_NS + IASG_CLK_NS - 1) / IASG_CLK_NS;

  // Strap levels: ground, resistor to ground, resistor to supply, supply
  typedef enum logic [1:0] {
    IASG_STRAP_GND  = 2'b00,
    IASG_STRAP_RGND = 2'b01,
    IASG_STRAP_RVDD = 2'b10,
    IASG_STRAP_VDD  = 2'b11
  } iasg_strap_type;

  typedef struct packed {
    logic       valid;
    logic [6:0] addr;
  } iasg_addr_type;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } iasg_byte_type;

endpackage

// [hw/iasg_cksum.sv]
// Running checksum of received command bytes
`timescale 1ns/1ns
`default_nettype none

module iasg_cksum
  import iasg_pkg::*;
(
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          reset,
  // Byte stream
  input  wire iasg_byte_type rx_byte,
  input  wire logic          clear,
  // Result
  output logic [7:0]         sum
);

  logic [7:0] sum_reg;
  logic [7:0] sum_next;

  // CRC-8, polynomial x^8+x^2+x+1, one byte per cycle
  function automatic logic [7:0] crc8_step(input logic [7:0] crc, input logic [7:0] data);
    logic [7:0] c;
    c = crc ^ data;
    for (int i = 0; i < 8; i++) begin
      c = c[7] ? ((c << 1) ^ 8'h07) : (c << 1);
    end
    return c;
  endfunction

  always_comb begin
    sum_next = sum_reg;
    if (clear) begin
      sum_next = IASG_CKSUM_RESET;
    end else if (rx_byte.valid) begin
      sum_next = crc8_step(sum_reg, rx_byte.data);
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sum_reg <= IASG_CKSUM_RESET;
    end else begin
      sum_reg <= sum_next;
    end
  end

  assign sum = sum_reg;

endmodule

`default_nettype wire

// [hw/iasg_top.sv]
// I2C target address selection, global address match and command checksum
// Operation
// [RULE_01] In I2C mode with global enable set, also accept address 0x48.
// [RULE_02] Host ignores ACK/NACK on broadcast writes; many targets answer together.
// [RULE_03] Keep readable checksum of received commands for host verification.
// [RULE_04] Global enable: 0 disables, 1 enables; resets to 1.
// [RULE_05] Local address sampled from select pin when shutdown pin releases.
// [RULE_06] Writing 1 to re-detect resamples the pin and updates address.
// [RULE_07] Local address is 10011xx, low bits from pin: 0x4C to 0x4F.
// [RULE_08] Re-detect control clears itself once the pin has been resampled.
`timescale 1ns/1ns
`default_nettype none

module iasg_top
  import iasg_pkg::*;
#(
  parameter int SETTLE_CYC = IASG_SETTLE_CYC
)
(
  // Clock and reset
  input  wire logic                    clk,
  input  wire logic                    reset,
  // Device pins
  input  wire logic                    shutdown_n_pin,
  input  wire iasg_strap_type          address_select_pin,
  input  wire logic                    i2c_mode,
  // Control writes from the register map
  input  wire logic                    global_address_enable_wr,
  input  wire logic                    global_address_enable_wdata,
  input  wire logic                    address_redetect_wr,
  input  wire logic                    address_redetect_wdata,
  input  wire logic                    command_checksum_clear,
  // Address phase from the I2C target
  input  wire iasg_addr_type           bus_addr,
  // Command bytes received after an address match
  input  wire iasg_byte_type           cmd_byte,
  // Results
  output logic                         addr_match,
  output logic                         addr_match_global,
  output logic [6:0]                   local_address,
  output logic                         global_address_enable,
  output logic                         address_redetect,
  output logic [7:0]                   command_checksum
);

  import iasg_pkg::*;

  typedef enum logic [1:0] {
    IASG_ST_SHUTDOWN = 2'b00,
    IASG_ST_SETTLE   = 2'b01,
    IASG_ST_RUN      = 2'b10
  } iasg_state_type;

  localparam int CNT_W = (SETTLE_CYC > 1) ? $clog2(SETTLE_CYC + 1) : 1;

  // Capture group
  iasg_state_type   state_reg;
  iasg_state_type   state_next;
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic             sd_prev_reg;
  logic             sd_prev_next;
  // Strap group
  logic [1:0]       strap_reg;
  logic [1:0]       strap_next;
  // Control group
  logic             gbl_en_reg;
  logic             gbl_en_next;
  logic             redet_reg;
  logic             redet_next;
  // Match group
  logic             match_reg;
  logic             match_next;
  logic             match_gbl_reg;
  logic             match_gbl_next;
  // Shared
  logic [7:0]       sum;
  logic             sample_now;
  logic             running;

  function automatic logic [6:0] local_from_strap(input logic [1:0] strap);
    return {IASG_LOCAL_PREFIX, strap};
  endfunction

  // Broadcast address is fixed; the enable and I2C mode gate it
  function automatic logic is_global(input logic [6:0] addr);
    return addr == IASG_GLOBAL_ADDR;
  endfunction

  // Matches stay off through shutdown and settle until each capture ends, so a host
  // probing during settle sees silence rather than a stale address
  assign running = (state_reg == IASG_ST_RUN);

  // Pin is sampled once the settle time after release has passed
  always_comb begin
    state_next   = state_reg;
    cnt_next     = cnt_reg;
    sample_now   = 1'b0;
    sd_prev_next = shutdown_n_pin;
    unique case (state_reg)
      IASG_ST_SHUTDOWN: begin
        if (shutdown_n_pin && !sd_prev_reg) begin
          state_next = IASG_ST_SETTLE;
          cnt_next   = CNT_W'(SETTLE_CYC - 1);
        end
      end
      IASG_ST_SETTLE: begin
        if (!shutdown_n_pin) begin
          state_next = IASG_ST_SHUTDOWN;
        end else if (cnt_reg == '0) begin
          sample_now = 1'b1;                                     // [RULE_05]
          state_next = IASG_ST_RUN;
        end else begin
          cnt_next = cnt_reg - CNT_W'(1);
        end
      end
      IASG_ST_RUN: begin
        if (!shutdown_n_pin) begin
          state_next = IASG_ST_SHUTDOWN;
        end else if (redet_reg) begin
          sample_now = 1'b1;                                     // [RULE_06]
        end
      end
      default: begin
        state_next = IASG_ST_SHUTDOWN;
      end
    endcase
  end

  // Released pin at reset release counts as a fresh release
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_reg   <= IASG_ST_SHUTDOWN;
      cnt_reg     <= '0;
      sd_prev_reg <= 1'b0;
    end else begin
      state_reg   <= state_next;
      cnt_reg     <= cnt_next;
      sd_prev_reg <= sd_prev_next;
    end
  end

  // Strap is only taken on a capture or a resample
  always_comb begin
    strap_next = sample_now ? address_select_pin : strap_reg;   // [RULE_07]
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      strap_reg <= IASG_STRAP_RESET;
    end else begin
      strap_reg <= strap_next;
    end
  end

  // Software write wins; otherwise clear after the resample
  always_comb begin
    gbl_en_next = global_address_enable_wr ? global_address_enable_wdata : gbl_en_reg; // [RULE_04]
    if (address_redetect_wr) begin
      redet_next = address_redetect_wdata;
    end else if (redet_reg && running) begin
      redet_next = 1'b0;                                         // [RULE_08]
    end else begin
      redet_next = redet_reg;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      gbl_en_reg <= IASG_GBL_EN_RESET;
      redet_reg  <= IASG_REDETECT_RESET;
    end else begin
      gbl_en_reg <= gbl_en_next;
      redet_reg  <= redet_next;
    end
  end

  // Only answer once an address is known and the device is up
  always_comb begin
    match_gbl_next = 1'b0;
    match_next     = 1'b0;
    if (bus_addr.valid && running && i2c_mode) begin
      match_gbl_next = gbl_en_reg && is_global(bus_addr.addr);  // [RULE_01]
      match_next     = match_gbl_next || (bus_addr.addr == local_from_strap(strap_reg));
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      match_reg     <= 1'b0;
      match_gbl_reg <= 1'b0;
    end else begin
      match_reg     <= match_next;
      match_gbl_reg <= match_gbl_next;
    end
  end

  // Broadcast writes cannot be trusted by ACK, so every byte feeds the sum except one that arrives in the same cycle as a clear
  iasg_cksum u_cksum (
    .clk     (clk),
    .reset   (reset),
    .rx_byte (cmd_byte),
    .clear   (command_checksum_clear),
    .sum     (sum)
  );                                                             // [RULE_03]

  always_comb begin
    addr_match            = match_reg;
    addr_match_global     = match_gbl_reg;
    local_address         = local_from_strap(strap_reg);
    global_address_enable = gbl_en_reg;
    address_redetect      = redet_reg;
    command_checksum      = sum;
  end

endmodule

`default_nettype wire

// [tb/iasg_monitor.sv]
// Checker for address matching, capture and checksum
`timescale 1ns/1ns
`default_nettype none
module iasg_monitor
  import iasg_pkg::*;
#(parameter int SETTLE_CYC = 4)
(
  // Inputs of the block
  input wire logic                    clk,
  input wire logic                    reset,
  input wire logic                    shutdown_n_pin,
  input wire iasg_pkg::iasg_strap_type address_select_pin,
  input wire logic                    i2c_mode,
  input wire logic                    command_checksum_clear,
  input wire iasg_pkg::iasg_addr_type bus_addr,
  input wire iasg_pkg::iasg_byte_type cmd_byte,
  // Outputs of the block
  input wire logic                    addr_match,
  input wire logic                    addr_match_global,
  input wire logic [6:0]              local_address,
  input wire logic                    global_address_enable,
  input wire logic                    address_redetect,
  input wire logic [7:0]              command_checksum
);
  localparam int D = SETTLE_CYC + 1;
  default clocking dc @(posedge clk); endclocking
  default disable iff (reset);
  property p_gbl;
    addr_match_global |-> addr_match && $past(bus_addr.addr) == IASG_GLOBAL_ADDR && $past(i2c_mode);
  endproperty
  a_gbl: assert property (p_gbl) else $error("bad global hit");
  property p_en;
    addr_match_global |-> $past(global_address_enable);
  endproperty
  a_en: assert property (p_en) else $error("global hit while disabled");
  property p_loc;
    bus_addr.valid && i2c_mode && bus_addr.addr == local_address |=> addr_match && !addr_match_global;
  endproperty
  a_loc: assert property (p_loc) else $error("local address missed");
  property p_cap;
    $rose(shutdown_n_pin) |-> ##D local_address == {IASG_LOCAL_PREFIX, $past(address_select_pin)};
  endproperty
  a_cap: assert property (p_cap) else $error("capture wrong");
  property p_red;
    address_redetect |=> local_address[1:0] == $past(address_select_pin);
  endproperty
  a_red: assert property (p_red) else $error("resample wrong");
  property p_clr;
    address_redetect |=> !address_redetect;
  endproperty
  a_clr: assert property (p_clr) else $error("redetect stuck");
  property p_ck;
    !$past(cmd_byte.valid) && !$past(command_checksum_clear) |-> $stable(command_checksum);
  endproperty
  a_ck: assert property (p_ck) else $error("checksum moved");
  c_gbl: cover property (addr_match_global);
  c_red: cover property (address_redetect);
  c_ck: cover property (cmd_byte.valid ##1 $changed(command_checksum));
endmodule
bind iasg_top iasg_monitor #(.SETTLE_CYC(SETTLE_CYC)) mon (
  .clk                    (clk),
  .reset                  (reset),
  .shutdown_n_pin         (shutdown_n_pin),
  .address_select_pin     (address_select_pin),
  .i2c_mode               (i2c_mode),
  .command_checksum_clear (command_checksum_clear),
  .bus_addr               (bus_addr),
  .cmd_byte               (cmd_byte),
  .addr_match             (addr_match),
  .addr_match_global      (addr_match_global),
  .local_address          (local_address),
  .global_address_enable  (global_address_enable),
  .address_redetect       (address_redetect),
  .command_checksum       (command_checksum)
);
`default_nettype wire

// [tb/iasg_host.sv]
// Host controller model presenting addresses and command bytes
`timescale 1ns/1ns
`default_nettype none
module iasg_host
  import iasg_pkg::*;
(
  // Bus side
  input  wire logic                    clk,
  output var  iasg_pkg::iasg_addr_type bus_addr,
  output var  iasg_pkg::iasg_byte_type cmd_byte
);
  initial {bus_addr, cmd_byte} = '0;
  // Broadcasts never wait on an acknowledge
  task automatic send(input bit is_addr, input logic [7:0] v);
    @(posedge clk) #1;
    if (is_addr) bus_addr = {1'b1, v[6:0]};
    else cmd_byte = {1'b1, v};
    @(posedge clk) #1;
    // Idle fields toggle so stale values are never trusted
    bus_addr = {1'b0, ~bus_addr.addr};
    cmd_byte = {1'b0, ~cmd_byte.data};
  endtask
endmodule
`default_nettype wire

// [tb/iasg_top_tb.sv]
// Self-checking bench for the address select block
`timescale 1ns/1ns
`default_nettype none
module iasg_top_tb;
  import iasg_pkg::*;
  logic clk = 0, reset = 1, shutdown_n_pin = 0, i2c_mode = 1, command_checksum_clear = 0, seen = 0, ge = 1;
  logic global_address_enable_wr = 0, global_address_enable_wdata = 0;
  logic address_redetect_wr = 0, address_redetect_wdata = 0;
  logic addr_match, addr_match_global, global_address_enable, address_redetect;
  iasg_strap_type address_select_pin = IASG_STRAP_GND;
  iasg_addr_type bus_addr;
  iasg_byte_type cmd_byte;
  logic [6:0] local_address, xl;
  logic [7:0] command_checksum, crc, r;
  logic [1:0] q[$];
  logic [31:0] s = 32'h0000_D2B1;
  int failures = 0, comparisons = 0;
  iasg_top uut (
    .clk                         (clk),
    .reset                       (reset),
    .shutdown_n_pin              (shutdown_n_pin),
    .address_select_pin          (address_select_pin),
    .i2c_mode                    (i2c_mode),
    .global_address_enable_wr    (global_address_enable_wr),
    .global_address_enable_wdata (global_address_enable_wdata),
    .address_redetect_wr         (address_redetect_wr),
    .address_redetect_wdata      (address_redetect_wdata),
    .command_checksum_clear      (command_checksum_clear),
    .bus_addr                    (bus_addr),
    .cmd_byte                    (cmd_byte),
    .addr_match                  (addr_match),
    .addr_match_global           (addr_match_global),
    .local_address               (local_address),
    .global_address_enable       (global_address_enable),
    .address_redetect            (address_redetect),
    .command_checksum            (command_checksum)
  );
  iasg_host host (
    .clk      (clk),
    .bus_addr (bus_addr),
    .cmd_byte (cmd_byte)
  );
  function automatic logic [7:0] rnd();
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s[7:0];
  endfunction
  function automatic logic [7:0] f(input logic [7:0] c, d);
    c ^= d;
    repeat (8) c = c[7] ? (c << 1) ^ 8'h07 : c << 1;
    return c;
  endfunction
  task automatic chk(input logic [7:0] g, e, input string what);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("ERROR %0t %s got %h exp %h", $time, what, g, e);
    end
  endtask
  task automatic chk_match(input logic [1:0] g, e);
    chk({6'h0, g}, {6'h0, e}, "match");
  endtask
  task automatic chk_addr(input logic [6:0] g, e);
    chk({1'b0, g}, {1'b0, e}, "address");
  endtask
  task automatic chk_ctl(input logic [1:0] g, e);
    chk({6'h0, g}, {6'h0, e}, "control");
  endtask
  task automatic chk_sum(input logic [7:0] g, e);
    chk(g, e, "checksum");
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic ctl(input bit g, input logic v);
    tick(1);
    if (g) {global_address_enable_wr, global_address_enable_wdata} = {1'b1, v};
    else {address_redetect_wr, address_redetect_wdata} = {1'b1, v};
    tick(1);
    global_address_enable_wr = 0;
    address_redetect_wr = 0;
  endtask
  task automatic adr(input logic [6:0] a);
    logic g;
    g = i2c_mode && ge && a == IASG_GLOBAL_ADDR;
    q.push_back({i2c_mode && a == xl || g, g});
    host.send(1, {1'b0, a});
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge clk) seen <= bus_addr.valid;
  always @(negedge clk) if (seen) chk_match({addr_match, addr_match_global}, q.pop_front());
  initial forever #5 clk = ~clk;
  initial begin
    #5000;
    failures++;
    report_and_stop();
  end
  initial begin
    tick(10);
    reset = 0;
    chk_addr(local_address, 7'h4C);
    chk_ctl({global_address_enable, address_redetect}, 2'h2);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      address_select_pin = iasg_strap_type'(i);
      shutdown_n_pin = 0;
      tick(2);
      shutdown_n_pin = 1;
      tick(6);
      xl = {IASG_LOCAL_PREFIX, address_select_pin};
      chk_addr(local_address, xl);
    end
    $display("test capture done");
    for (int i = 0; i < 4; i++) begin
      ge = i != 1;
      ctl(1, ge);
      chk_ctl({global_address_enable, address_redetect}, {ge, 1'b0});
      i2c_mode = i != 3;
      adr(xl);
      adr(IASG_GLOBAL_ADDR);
      r = rnd();
      adr(r[6:0]);
    end
    $display("test match done");
    i2c_mode = 1;
    address_select_pin = IASG_STRAP_RGND;
    ctl(0, 1);
    chk_ctl({global_address_enable, address_redetect}, {ge, 1'b1});
    tick(1);
    xl = {IASG_LOCAL_PREFIX, address_select_pin};
    chk_addr(local_address, xl);
    chk_ctl({global_address_enable, address_redetect}, {ge, 1'b0});
    adr(xl);
    $display("test redetect done");
    repeat (2) begin
      command_checksum_clear = 1;
      tick(1);
      command_checksum_clear = 0;
      crc = 0;
      repeat (6) begin
        r = rnd();
        crc = f(crc, r);
        host.send(0, r);
      end
      tick(1);
      chk_sum(command_checksum, crc);
    end
    $display("test checksum done");
    report_and_stop();
  end
endmodule
`default_nettype wire
